// ### verilog/desf_top.v
// Drive error and status word, bits 8 to 17, with APB access and interrupt.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`include "desf_consts.vh"
module desf_top #(
	parameter VW = 11,
	parameter SPW = 16,
	parameter UV_HOLD_CYCLES = `DESF_UV_HOLD_MS * (`DESF_CLK_HZ / 1000)
) (
	input wire I_REF_CLK,
	input wire I_RST_N,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire O_PREADY,
	output reg [31:0] O_PRDATA,
	output reg O_PSLVERR,
	input wire [15:0] I_MEASURED_TEMPERATURE,
	input wire I_AC_MISSING,
	input wire [VW-1:0] I_DC_BUS_VOLTS,
	input wire [7:0] I_CTRL_SUPPLY_VOLTS,
	input wire I_PHASE_OVERCURRENT,
	input wire I_VEL_VALID,
	input wire [SPW-1:0] I_VEL_RPM,
	input wire I_ENCODER_FAULT,
	input wire I_POS_INSIDE_LIMITS,
	output wire O_POSITION_LIMIT_OVERRIDE,
	output wire O_UNDERVOLTAGE_LIVE_DETECT,
	output wire O_IRQ
);

	localparam SUMW = SPW + `DESF_AVG_SHIFT;
	// Integer forms first, then cut on purpose to the width they meet.
	localparam UV_THR_N = `DESF_UV_VOLTS;
	localparam UV_REL_N = `DESF_UV_VOLTS + (`DESF_UV_VOLTS / 4);
	localparam OV_A_N = `DESF_OV_VOLTS_A;
	localparam OV_B_N = `DESF_OV_VOLTS_B;
	localparam OV_C_N = `DESF_OV_VOLTS_C;
	localparam SPD_A_N = `DESF_SPEED_RPM_A * `DESF_AVG_SAMPLES;
	localparam SPD_B_N = `DESF_SPEED_RPM_B * `DESF_AVG_SAMPLES;
	localparam SUP_A_N = `DESF_SUPPLY_VOLTS_A;
	localparam SUP_B_N = `DESF_SUPPLY_VOLTS_B;
	localparam [VW-1:0] UV_THR = UV_THR_N[VW-1:0];
	localparam [VW:0] UV_REL = UV_REL_N[VW:0];
	localparam [VW-1:0] OV_A = OV_A_N[VW-1:0];
	localparam [VW-1:0] OV_B = OV_B_N[VW-1:0];
	localparam [VW-1:0] OV_C = OV_C_N[VW-1:0];
	localparam [SUMW-1:0] SPD_A = SPD_A_N[SUMW-1:0];
	localparam [SUMW-1:0] SPD_B = SPD_B_N[SUMW-1:0];
	localparam [7:0] SUP_A = SUP_A_N[7:0];
	localparam [7:0] SUP_B = SUP_B_N[7:0];
	localparam LO = `DESF_BIT_TEMP;
	localparam [31:0] RST_WORD = `DESF_RST_ERR >> LO;
	localparam [9:0] RST_FLAGS = RST_WORD[9:0];

	// Flags that software can clear with a write of one.
	localparam [9:0] CLEARABLE = 10'h02b;
	// Flags that only a reset removes.
	localparam [9:0] RESET_ONLY = 10'h294;

	function [11:0] byte_addr;
		input [7:0] idx;
		begin
			byte_addr = {2'b00, idx, 2'b00};
		end
	endfunction

	function hit;
		input [11:0] addr;
		input [7:0] idx;
		begin
			hit = (addr == byte_addr(idx));
		end
	endfunction

	// Bus decode.
	wire setup = I_PSEL & ~I_PENABLE;
	wire access = I_PSEL & I_PENABLE;
	wire wr = access & I_PWRITE;
	wire sel_uv = hit(I_PADDR, `DESF_IDX_UV_CFG);
	wire sel_temp = hit(I_PADDR, `DESF_IDX_TEMP);
	wire sel_tlim = hit(I_PADDR, `DESF_IDX_TEMP_LIM);
	wire sel_err = hit(I_PADDR, `DESF_IDX_ERR);
	wire sel_var = hit(I_PADDR, `DESF_IDX_VARIANT);
	wire sel_istat = hit(I_PADDR, `DESF_IDX_IRQ_STAT);
	wire sel_imask = hit(I_PADDR, `DESF_IDX_IRQ_MASK);
	wire mapped = sel_uv | sel_temp | sel_tlim | sel_err | sel_var |
		sel_istat | sel_imask;

	// Zero wait states: read data is captured in the setup cycle.
	assign O_PREADY = 1'b1;

	// Software-visible configuration.
	reg uv_cfg;
	reg [15:0] temp_limit;
	reg [3:0] variant;
	reg [9:0] irq_mask;
	reg [9:0] irq_status;

	// Error flags, bit 0 here is bit 8 of the word.
	reg [9:0] flags;
	reg [9:0] next_flags;
	reg plim_override;
	reg next_plim_override;

	always @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			uv_cfg <= `DESF_RST_UV_CFG;
			temp_limit <= `DESF_RST_TEMP_LIM;
			variant <= `DESF_RST_VARIANT;
			irq_mask <= `DESF_RST_IRQ_MASK;
		end else if (wr) begin
			if (sel_uv) begin
				uv_cfg <= I_PWDATA[0];
			end
			if (sel_tlim) begin
				temp_limit <= I_PWDATA[15:0];
			end
			if (sel_var) begin
				variant <= I_PWDATA[3:0];
			end
			if (sel_imask) begin
				irq_mask <= I_PWDATA[9:0];
			end
		end
	end

	// Under-voltage condition with hysteresis on release.
	reg uv_cond;
	wire bus_low = (I_DC_BUS_VOLTS < UV_THR);
	wire bus_clear = ({1'b0, I_DC_BUS_VOLTS} >= UV_REL);
	wire uv_live;

	always @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			uv_cond <= 1'b0;
		end else if (I_AC_MISSING | bus_low) begin
			uv_cond <= 1'b1;
		end else if (bus_clear) begin
			uv_cond <= 1'b0;
		end
	end

	desf_holdoff #(
		.HOLD_CYCLES(UV_HOLD_CYCLES),
		.CW(32)
	) u_uv_hold (
		.i_clk(I_REF_CLK),
		.i_rst_n(I_RST_N),
		.i_cond(uv_cond),
		.o_level(uv_live)
	);

	// Over-voltage limit by variant.
	reg [VW-1:0] ov_limit;
	always @* begin
		case (variant[`DESF_VAR_OV_LSB+1:`DESF_VAR_OV_LSB])
			2'h1: ov_limit = OV_B;
			2'h2: ov_limit = OV_C;
			default: ov_limit = OV_A;
		endcase
	end
	wire ov_now = (I_DC_BUS_VOLTS > ov_limit);

	// Sixteen-sample speed average kept as a running sum of magnitudes.
	wire [SPW-1:0] vel_hist [0:`DESF_AVG_SAMPLES-1];
	reg [SUMW-1:0] vel_sum;
	wire [SPW-1:0] vel_mag = I_VEL_RPM[SPW-1] ? (~I_VEL_RPM + 1'b1) :
		I_VEL_RPM;
	wire [SUMW-1:0] vel_oldest = {{`DESF_AVG_SHIFT{1'b0}},
		vel_hist[`DESF_AVG_SAMPLES-1]};
	wire [SUMW-1:0] vel_new = {{`DESF_AVG_SHIFT{1'b0}}, vel_mag};

	always @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			vel_sum <= {SUMW{1'b0}};
		end else if (I_VEL_VALID) begin
			vel_sum <= vel_sum + vel_new - vel_oldest;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `DESF_AVG_SAMPLES; g = g + 1) begin : g_hist
			reg [SPW-1:0] stage;
			wire [SPW-1:0] stage_in;
			if (g == 0) begin : g_head
				assign stage_in = vel_mag;
			end else begin : g_tail
				assign stage_in = vel_hist[g-1];
			end
			always @(posedge I_REF_CLK or negedge I_RST_N) begin
				if (!I_RST_N) begin
					stage <= {SPW{1'b0}};
				end else if (I_VEL_VALID) begin
					stage <= stage_in;
				end
			end
			assign vel_hist[g] = stage;
		end
	endgenerate

	// Comparing the sum against sixteen times the limit avoids a divider.
	wire [SUMW-1:0] speed_limit = variant[`DESF_VAR_SPEED] ? SPD_B : SPD_A;
	wire speed_now = (vel_sum > speed_limit);

	wire [7:0] sup_limit = variant[`DESF_VAR_SUPPLY] ? SUP_B : SUP_A;
	wire supply_now = (I_CTRL_SUPPLY_VOLTS < sup_limit);

	// Conditions in word order, bits 8 to 17.
	wire [9:0] cond;
	assign cond[0] = (I_MEASURED_TEMPERATURE > temp_limit);
	assign cond[1] = uv_cond & uv_cfg;
	assign cond[2] = 1'b0;
	assign cond[3] = ov_now;
	assign cond[4] = I_PHASE_OVERCURRENT;
	assign cond[5] = speed_now;
	assign cond[6] = 1'b0;
	assign cond[7] = I_ENCODER_FAULT;
	assign cond[8] = 1'b0;
	assign cond[9] = supply_now;

	wire err_wr = wr & sel_err;
	wire [9:0] clr = err_wr ? (I_PWDATA[17:8] & CLEARABLE) : 10'h000;

	// A new condition in the clearing cycle keeps the flag set.
	always @* begin
		next_flags = (flags & ~clr) | cond;
		next_flags[2] = 1'b0;
		next_flags[6] = 1'b0;
		next_flags[8] = 1'b0;
		next_flags = next_flags | (flags & RESET_ONLY);
	end

	always @* begin
		next_plim_override = plim_override;
		if (I_POS_INSIDE_LIMITS) begin
			next_plim_override = 1'b0;
		end
		if (err_wr) begin
			next_plim_override = I_PWDATA[`DESF_BIT_PLIM_OVR];
		end
	end

	always @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			flags <= RST_FLAGS;
			plim_override <= 1'b0;
		end else begin
			flags <= next_flags;
			plim_override <= next_plim_override;
		end
	end

	assign O_POSITION_LIMIT_OVERRIDE = plim_override;
	assign O_UNDERVOLTAGE_LIVE_DETECT = uv_live;

	// Assembled word; bits 0 to 7 belong elsewhere and read as zero here.
	wire [31:0] err_word;
	assign err_word[7:0] = 8'h00;
	assign err_word[`DESF_BIT_TEMP] = flags[0];
	assign err_word[`DESF_BIT_UV] = flags[1];
	assign err_word[`DESF_BIT_UV_LIVE] = uv_live;
	assign err_word[`DESF_BIT_OV] = flags[3];
	assign err_word[`DESF_BIT_PEAK] = flags[4];
	assign err_word[`DESF_BIT_SPEED] = flags[5];
	assign err_word[`DESF_BIT_PLIM_OVR] = plim_override;
	assign err_word[`DESF_BIT_ENC] = flags[7];
	assign err_word[`DESF_BIT_FILT] = 1'b0;
	assign err_word[`DESF_BIT_SUPPLY] = flags[9];
	assign err_word[31:18] = 14'h0000;

	// Interrupt events: each flag rising, plus the live detect and the override rising.
	wire [9:0] shown = err_word[17:8];
	reg [9:0] shown_d;
	wire [9:0] events = shown & ~shown_d & ~10'h010 | (shown & ~shown_d &
		10'h010);
	wire [9:0] irq_clr = (wr & sel_istat) ? I_PWDATA[9:0] : 10'h000;

	always @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			shown_d <= 10'h000;
			irq_status <= 10'h000;
		end else begin
			shown_d <= shown;
			irq_status <= (irq_status & ~irq_clr) | events;
		end
	end

	assign O_IRQ = |(irq_status & irq_mask);

	// Read mux.
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h00000000;
		if (sel_uv) begin
			rdata[0] = uv_cfg;
		end
		if (sel_temp) begin
			rdata[15:0] = I_MEASURED_TEMPERATURE;
		end
		if (sel_tlim) begin
			rdata[15:0] = temp_limit;
		end
		if (sel_err) begin
			rdata = err_word;
		end
		if (sel_var) begin
			rdata[3:0] = variant;
		end
		if (sel_istat) begin
			rdata[9:0] = irq_status;
		end
		if (sel_imask) begin
			rdata[9:0] = irq_mask;
		end
	end

	always @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PRDATA <= 32'h00000000;
			O_PSLVERR <= 1'b0;
		end else if (setup) begin
			O_PRDATA <= I_PWRITE ? 32'h00000000 : rdata;
			O_PSLVERR <= ~mapped;
		end else if (!I_PSEL) begin
			O_PSLVERR <= 1'b0;
		end
	end

endmodule

// ### verilog/desf_consts.vh
// Register map, field positions, reset values and limits of the error word.
`ifndef DESF_CONSTS_VH
`define DESF_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define DESF_IDX_UV_CFG 8'h17
`define DESF_IDX_TEMP 8'h1d
`define DESF_IDX_TEMP_LIM 8'h1f
`define DESF_IDX_ERR 8'h23
`define DESF_IDX_VARIANT 8'h40
`define DESF_IDX_IRQ_STAT 8'h41
`define DESF_IDX_IRQ_MASK 8'h42

// Bit positions inside the error word.
`define DESF_BIT_TEMP 8
`define DESF_BIT_UV 9
`define DESF_BIT_UV_LIVE 10
`define DESF_BIT_OV 11
`define DESF_BIT_PEAK 12
`define DESF_BIT_SPEED 13
`define DESF_BIT_PLIM_OVR 14
`define DESF_BIT_ENC 15
`define DESF_BIT_FILT 16
`define DESF_BIT_SUPPLY 17

// Variant register fields.
`define DESF_VAR_OV_LSB 0
`define DESF_VAR_SPEED 2
`define DESF_VAR_SUPPLY 3

// Reset values.
`define DESF_RST_ERR 32'h00000000
`define DESF_RST_TEMP_LIM 16'h0050
`define DESF_RST_UV_CFG 1'b0
`define DESF_RST_VARIANT 4'h0
`define DESF_RST_IRQ_MASK 10'h000

// Limits in volts and RPM, and the speed average length.
`define DESF_UV_VOLTS 80
`define DESF_OV_VOLTS_A 450
`define DESF_OV_VOLTS_B 1000
`define DESF_OV_VOLTS_C 63
`define DESF_SPEED_RPM_A 3600
`define DESF_SPEED_RPM_B 4300
`define DESF_SUPPLY_VOLTS_A 12
`define DESF_SUPPLY_VOLTS_B 9
`define DESF_AVG_SAMPLES 16
`define DESF_AVG_SHIFT 4

// Timing: clock rate and the under-voltage release hold time.
`define DESF_CLK_HZ 50000000
`define DESF_UV_HOLD_MS 1000

`endif

// ### verilog/desf_holdoff.v
// Release delay: output follows a set condition, drops after a quiet time.
`timescale 1ns/10ps
module desf_holdoff #(
	parameter HOLD_CYCLES = 50000000,
	parameter CW = 26
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_cond,
	output reg o_level
);

	reg [CW-1:0] quiet;

	// Any return of the condition restarts the full quiet period.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			quiet <= {CW{1'b0}};
			o_level <= 1'b0;
		end else if (i_cond) begin
			quiet <= {CW{1'b0}};
			o_level <= 1'b1;
		end else if (o_level) begin
			if (quiet >= HOLD_CYCLES[CW-1:0] - 1'b1) begin
				o_level <= 1'b0;
				quiet <= {CW{1'b0}};
			end else begin
				quiet <= quiet + 1'b1;
			end
		end
	end

endmodule

// ### verif/desf_meas_model.sv
// Far-side model: velocity estimator that strobes one sample every other cycle.
`timescale 1ns/10ps
module desf_meas_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_rpm,
	output logic o_vld,
	output logic [15:0] o_smp
);
	// Between strobes the sample lines carry the inverse value, so a design
	// that reads them without the strobe sees garbage, not a lucky match.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_vld <= 1'b0;
			o_smp <= 16'h0000;
		end else begin
			o_vld <= !o_vld;
			o_smp <= o_vld ? ~o_smp : i_rpm;
		end
	end
endmodule

// ### verif/desf_checker.sv
// Port-level assertions for the drive error word block.
`timescale 1ns/10ps
`include "desf_consts.vh"
module desf_checker #(
	parameter VW = 11,
	parameter SPW = 16,
	parameter UV_HOLD_CYCLES = `DESF_UV_HOLD_MS * (`DESF_CLK_HZ / 1000)
) (
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic O_PREADY,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PSLVERR,
	input wire logic I_AC_MISSING,
	input wire logic [VW-1:0] I_DC_BUS_VOLTS,
	input wire logic I_PHASE_OVERCURRENT,
	input wire logic I_ENCODER_FAULT,
	input wire logic I_POS_INSIDE_LIMITS,
	input wire logic O_POSITION_LIMIT_OVERRIDE,
	input wire logic O_UNDERVOLTAGE_LIVE_DETECT,
	input wire logic O_IRQ
);
	localparam int UV_REL = `DESF_UV_VOLTS * 5 / 4;
	logic seen_pk;
	logic seen_enc;
	int quiet;
	wire [7:0] idx = I_PADDR[9:2];
	wire hit_err = I_PADDR == 12'h08c;
	wire rd_err = I_PSEL && !I_PENABLE && !I_PWRITE && hit_err;
	wire ovr_wr = I_PSEL && I_PENABLE && I_PWRITE && hit_err && I_PWDATA[14];
	wire mapped = I_PADDR[11:10] == 2'h0 && I_PADDR[1:0] == 2'h0 &&
		(idx == `DESF_IDX_UV_CFG || idx == `DESF_IDX_TEMP ||
		idx == `DESF_IDX_TEMP_LIM || idx == `DESF_IDX_ERR ||
		idx == `DESF_IDX_VARIANT || idx == `DESF_IDX_IRQ_STAT ||
		idx == `DESF_IDX_IRQ_MASK);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);
	// Quiet counts cycles with the under-voltage condition gone, hysteresis
	// included; it saturates so a long run cannot wrap it.
	always @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			seen_pk <= 1'b0;
			seen_enc <= 1'b0;
			quiet <= 0;
		end else begin
			seen_pk <= seen_pk | I_PHASE_OVERCURRENT;
			seen_enc <= seen_enc | I_ENCODER_FAULT;
			if (I_AC_MISSING || I_DC_BUS_VOLTS < UV_REL)
				quiet <= 0;
			else if (quiet < UV_HOLD_CYCLES)
				quiet <= quiet + 1;
		end
	end
	a_live_follows: assert property (I_AC_MISSING |-> ##[1:3]
		O_UNDERVOLTAGE_LIVE_DETECT) else $error("live bit not set");
	a_live_release: assert property ($fell(O_UNDERVOLTAGE_LIVE_DETECT)
		|-> quiet >= UV_HOLD_CYCLES - 2) else $error("live bit dropped early");
	a_override_src: assert property ($rose(O_POSITION_LIMIT_OVERRIDE)
		|-> $past(ovr_wr)) else $error("override set without a write");
	a_override_clr: assert property (O_POSITION_LIMIT_OVERRIDE &&
		I_POS_INSIDE_LIMITS && !ovr_wr |=> !O_POSITION_LIMIT_OVERRIDE)
		else $error("override not cleared inside limits");
	a_peak_kept: assert property (rd_err && $past(seen_pk, 2) |=>
		O_PRDATA[12]) else $error("peak current flag lost");
	a_enc_kept: assert property (rd_err && $past(seen_enc, 2) |=>
		O_PRDATA[15]) else $error("encoder flag lost");
	a_filt_zero: assert property (I_PSEL && I_PENABLE |->
		!O_PRDATA[16]) else $error("obsolete bit read as one");
	a_slverr_map: assert property (I_PSEL && I_PENABLE |->
		O_PREADY && O_PSLVERR == !mapped) else $error("bad bus answer");
	c_live_drop: cover property ($fell(O_UNDERVOLTAGE_LIVE_DETECT));
	c_override: cover property ($rose(O_POSITION_LIMIT_OVERRIDE));
	c_irq: cover property ($rose(O_IRQ));
endmodule
bind desf_top desf_checker #(.VW(VW), .SPW(SPW),
	.UV_HOLD_CYCLES(UV_HOLD_CYCLES)) u_desf_checker (.*);

// ### verif/desf_top_tb_top.sv
// Bench for the drive error word block: bus tasks and directed tests.
`timescale 1ns/10ps
module desf_top_tb_top;
	localparam int HOLD = 20;
	logic clk, rst_n, psel, pen, pwr, er, ac, pk, enc, pos;
	logic [11:0] pa;
	logic [31:0] pwd, rd;
	logic [15:0] temp, rpm;
	logic [10:0] bus;
	logic [7:0] sup;
	wire rdy, slv, irq, ovr, live, vld;
	wire [31:0] prd;
	wire [15:0] smp;
	int mismatches, tests_run, i;
	int ov[4] = '{450, 1000, 63, 450};
	int sp[2] = '{3600, 4300};
	desf_top #(.UV_HOLD_CYCLES(HOLD)) u_desf_top (.I_REF_CLK(clk),
		.I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(pa), .I_PWDATA(pwd), .O_PREADY(rdy), .O_PRDATA(prd),
		.O_PSLVERR(slv), .I_MEASURED_TEMPERATURE(temp), .I_AC_MISSING(ac),
		.I_DC_BUS_VOLTS(bus), .I_CTRL_SUPPLY_VOLTS(sup),
		.I_PHASE_OVERCURRENT(pk), .I_VEL_VALID(vld), .I_VEL_RPM(smp),
		.I_ENCODER_FAULT(enc), .I_POS_INSIDE_LIMITS(pos),
		.O_POSITION_LIMIT_OVERRIDE(ovr), .O_UNDERVOLTAGE_LIVE_DETECT(live),
		.O_IRQ(irq));
	desf_meas_model u_desf_meas_model (.i_clk(clk), .i_rst_n(rst_n),
		.i_rpm(rpm), .o_vld(vld), .o_smp(smp));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// The master waits for pready without assuming the zero-wait answer.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		rd = prd;
		er = slv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		{rst_n, psel, pen, pwr, ac, pk, enc} = 7'h00;
		pa = 12'h000;
		pwd = 32'h0;
		pos = 1'b1;
		temp = 16'h0020;
		rpm = 16'h0000;
		bus = 11'h12c;
		sup = 8'h18;
		tick(3);
		rst_n <= 1'b1;
		rdm(12'h08c, 32'hffffffff, 32'h0);
		rdm(12'h07c, 32'hffffffff, 32'h50);
		wr(12'h108, 32'h3ff);
		temp <= 16'h0051;
		tick(4);
		rdm(12'h08c, 32'h100, 32'h100);
		@(negedge clk) chk(irq, 1'b1);
		tick(1);
		temp <= 16'h0020;
		tick(2);
		rdm(12'h08c, 32'h100, 32'h100);
		wr(12'h104, 32'h3ff);
		wr(12'h108, 32'h0);
		wr(12'h08c, 32'h100);
		rdm(12'h08c, 32'h100, 32'h0);
		temp <= 16'h0051;
		tick(4);
		@(negedge clk) chk(irq, 1'b0);
		rdm(12'h104, 32'h1, 32'h1);
		temp <= 16'h0020;
		ac <= 1'b1;
		tick(4);
		rdm(12'h08c, 32'h600, 32'h400);
		wr(12'h05c, 32'h1);
		tick(4);
		rdm(12'h08c, 32'h200, 32'h200);
		ac <= 1'b0;
		bus <= 11'h05a;
		tick(HOLD + 10);
		rdm(12'h08c, 32'h400, 32'h400);
		bus <= 11'h064;
		tick(HOLD - 5);
		rdm(12'h08c, 32'h400, 32'h400);
		tick(10);
		rdm(12'h08c, 32'h400, 32'h0);
		wr(12'h08c, 32'h200);
		rdm(12'h08c, 32'h200, 32'h0);
		bus <= 11'h046;
		tick(4);
		rdm(12'h08c, 32'h200, 32'h200);
		bus <= 11'h12c;
		wr(12'h05c, 32'h0);
		for (i = 0; i < 4; i++) begin
			wr(12'h100, 32'(i));
			bus <= 11'(ov[i]);
			tick(4);
			wr(12'h08c, 32'h800);
			rdm(12'h08c, 32'h800, 32'h0);
			bus <= 11'(ov[i] + 1);
			tick(4);
			rdm(12'h08c, 32'h800, 32'h800);
			bus <= 11'h12c;
		end
		for (i = 0; i < 2; i++) begin
			wr(12'h100, 32'(i * 4));
			rpm <= 16'(sp[i]);
			tick(40);
			wr(12'h08c, 32'h2000);
			rdm(12'h08c, 32'h2000, 32'h0);
			rpm <= 16'(sp[i] + 1);
			tick(40);
			rdm(12'h08c, 32'h2000, 32'h2000);
			rpm <= 16'h0000;
		end
		pk <= 1'b1;
		enc <= 1'b1;
		sup <= 8'h0a;
		tick(1);
		{pk, enc} <= 2'h0;
		sup <= 8'h18;
		tick(3);
		wr(12'h08c, 32'hffffffff);
		rdm(12'h08c, 32'h39000, 32'h29000);
		pos <= 1'b0;
		wr(12'h08c, 32'h4000);
		rdm(12'h08c, 32'h4000, 32'h4000);
		@(negedge clk) chk(ovr, 1'b1);
		tick(1);
		pos <= 1'b1;
		tick(3);
		@(negedge clk) chk(ovr, 1'b0);
		tick(1);
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		rdm(12'h08c, 32'hffffffff, 32'h0);
		wr(12'h100, 32'h8);
		sup <= 8'h0a;
		tick(3);
		rdm(12'h08c, 32'h20000, 32'h0);
		sup <= 8'h08;
		tick(3);
		rdm(12'h08c, 32'h20000, 32'h20000);
		apb(1'b0, 12'h200, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		tally_and_finish;
	end
endmodule
